// File: hw/eik_ctrl.sv
// External interrupt, key-return and non-maskable acknowledge front end
//
// Summary of operation
// - Two-bit edge field per pin: 00 falling, 01 rising, 11 both, 10 none.
// - Pins 0-2 fields in low register bits 2-7; pin 3 in high bits 0-1.
// - Edge registers reset to zero and take whole-byte writes only.
// - Status bit 7 enables maskable accept; byte, bit, enable, disable writes.
// - Any vectored acknowledge clears the accept-enable bit, status pushed.
// - Status resets to 02H; bit 1 reads one, bits 2, 3, 5 zero.
// - Port 0 key control: bit 0 enables lines 0-3, bits 4-7 each line.
// - Port 6 key control works the same for port 6.
// - Key controls take bit and byte writes and reset to zero.
// - No pull-ups driven; detection continues regardless of pin direction.
// - Enabled key lines combined; any held low blocks other falling edges.
// - Non-maskable request taken regardless of enable, ahead of all others.
// - Non-maskable ack pushes status then PC, clears enable, loads vector.
// - Non-maskable request during its own pushes is held pending, taken once the PC low push is done.
// - Request flags set by event, cleared by ack, reset or software.
// - Mask flags reset to all ones.
`timescale 1ns/10ps
`default_nettype none
module eik_ctrl #(
  parameter logic [15:0] NMI_VEC_ADDR = eik_pkg::NMI_VECTOR
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // CPU memory access
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_wr,
  input  wire logic        mem_bit_wr,
  input  wire logic [2:0]  mem_bit_sel,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_rd,
  output logic      [7:0]  mem_rdata,
  output logic             mem_hit,
  // Dedicated status word control
  input  wire logic        enable_int_instr,
  input  wire logic        disable_int_instr,
  input  wire logic [7:0]  alu_flags,
  input  wire logic        alu_flags_wr,
  output logic      [7:0]  processor_status_word,
  // Maskable acknowledge from priority logic
  input  wire logic        int_ack,
  input  wire logic [5:0]  src_ack,
  output logic      [5:0]  int_pending,
  // Pins
  input  wire logic [3:0]  ext_int_pin,
  input  wire logic [7:0]  port0_pin,
  input  wire logic [7:0]  port6_pin,
  // Non-maskable request and acknowledge sequence
  input  wire logic        nmi_req,
  input  wire logic [15:0] cpu_pc,
  output logic             nmi_ack,
  output logic             push_wr,
  output logic      [7:0]  push_data,
  output logic             pc_load,
  output logic      [15:0] pc_load_addr
);

  // Byte or single-bit update of a register image
  function automatic logic [7:0] eik_merge(input logic [7:0] old,
                                           input logic       byte_we,
                                           input logic       bit_we,
                                           input logic [2:0] sel,
                                           input logic       val,
                                           input logic [7:0] wdata);
    logic [7:0] res;
    res = old;
    if (byte_we) begin
      res = wdata;
    end else if (bit_we) begin
      res[sel] = val;
    end
    return res;
  endfunction : eik_merge

  // Edge hit from a two-bit edge field
  function automatic logic eik_edge_hit(input logic [1:0] sel,
                                        input logic       prev,
                                        input logic       cur);
    logic hit;
    hit = 1'b0;
    case (sel)
      eik_pkg::EDGE_FALL: hit = prev & ~cur;
      eik_pkg::EDGE_RISE: hit = ~prev & cur;
      eik_pkg::EDGE_BOTH: hit = prev ^ cur;
      default:            hit = 1'b0;
    endcase
    return hit;
  endfunction : eik_edge_hit

  // Combined key level: disabled lines count as high
  function automatic logic eik_key_level(input logic [7:0] ctl,
                                         input logic [7:0] pins);
    logic [7:0] en;
    en = {ctl[7:eik_pkg::KR_LINE_LSB], {4{ctl[eik_pkg::KR_GROUP_BIT]}}};
    return &(pins | ~en);
  endfunction : eik_key_level

  logic [7:0]  edge_lo_r;
  logic [7:0]  edge_hi_r;
  logic [7:0]  kr0_r;
  logic [7:0]  kr6_r;
  logic [7:0]  psw_r;
  logic [3:0]  ext_req_r;
  logic        kr0_req_r;
  logic        kr6_req_r;
  logic [3:0]  ext_mask_r;
  logic        kr0_mask_r;
  logic        kr6_mask_r;
  logic [3:0]  ext_s1_r;
  logic [3:0]  ext_s2_r;
  logic [3:0]  ext_prev_r;
  logic [7:0]  p0_s1_r;
  logic [7:0]  p0_s2_r;
  logic [7:0]  p6_s1_r;
  logic [7:0]  p6_s2_r;
  logic        kr0_lvl_r;
  logic        kr6_lvl_r;
  logic [1:0]  edge_field [eik_pkg::N_EXT];
  logic [3:0]  ext_hit;
  logic        kr0_lvl;
  logic        kr6_lvl;
  logic        kr0_hit;
  logic        kr6_hit;
  logic [7:0]  if0_img;
  logic [7:0]  req2_img;
  logic [7:0]  mk0_img;
  logic [7:0]  mask2_img;
  logic [7:0]  if0_nxt;
  logic [7:0]  req2_nxt;
  logic [7:0]  mk0_nxt;
  logic [7:0]  mask2_nxt;
  logic [7:0]  psw_nxt;
  logic [7:0]  rdata_nxt;
  logic        hit_nxt;
  eik_pkg::eik_nmi_state_t nmi_st_r;
  logic        nmi_pend_r;
  logic [15:0] pc_snap_r;
  logic [7:0]  psw_snap_r;
  logic        nmi_start;

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ext_s1_r <= 4'h0;
      ext_s2_r <= 4'h0;
      p0_s1_r  <= 8'hFF;
      p0_s2_r  <= 8'hFF;
      p6_s1_r  <= 8'hFF;
      p6_s2_r  <= 8'hFF;
    end else begin
      ext_s1_r <= ext_int_pin;
      ext_s2_r <= ext_s1_r;
      p0_s1_r  <= port0_pin;
      p0_s2_r  <= p0_s1_r;
      p6_s1_r  <= port6_pin;
      p6_s2_r  <= p6_s1_r;
    end
  end

  // Previous levels for edge detection
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ext_prev_r <= 4'h0;
      kr0_lvl_r  <= 1'b1;
      kr6_lvl_r  <= 1'b1;
    end else begin
      ext_prev_r <= ext_s2_r;
      kr0_lvl_r  <= kr0_lvl;
      kr6_lvl_r  <= kr6_lvl;
    end
  end

  // Edge field extraction and detection
  always_comb begin
    for (int i = 0; i < eik_pkg::N_EXT - 1; i++) begin
      edge_field[i] = edge_lo_r[eik_pkg::EDGE_LO_LSB + 2*i +: 2];
    end
    edge_field[eik_pkg::N_EXT-1] = edge_hi_r[eik_pkg::EDGE_HI_LSB +: 2];
    for (int i = 0; i < eik_pkg::N_EXT; i++) begin
      ext_hit[i] = eik_edge_hit(edge_field[i], ext_prev_r[i],
                                ext_s2_r[i]);
    end
  end

  // Direction of the port does not matter: input levels are always read
  assign kr0_lvl = eik_key_level(kr0_r, p0_s2_r);
  assign kr6_lvl = eik_key_level(kr6_r, p6_s2_r);
  assign kr0_hit = kr0_lvl_r & ~kr0_lvl;
  assign kr6_hit = kr6_lvl_r & ~kr6_lvl;

  // Flag register images; foreign bits read as their reset level
  always_comb begin
    if0_img = eik_pkg::RST_ZERO;
    if0_img[eik_pkg::IF0_EXT_LSB +: 4] = ext_req_r;
    req2_img = eik_pkg::RST_ZERO;
    req2_img[eik_pkg::REQ2_KR0_BIT] = kr0_req_r;
    req2_img[eik_pkg::REQ2_KR6_BIT] = kr6_req_r;
    mk0_img = eik_pkg::RST_MASK;
    mk0_img[eik_pkg::IF0_EXT_LSB +: 4] = ext_mask_r;
    mask2_img = eik_pkg::RST_MASK;
    mask2_img[eik_pkg::REQ2_KR0_BIT] = kr0_mask_r;
    mask2_img[eik_pkg::REQ2_KR6_BIT] = kr6_mask_r;
  end

  // Software writes applied to images
  always_comb begin
    if0_nxt = eik_merge(if0_img, mem_wr && mem_addr == eik_pkg::ADDR_IF0,
                        mem_bit_wr && mem_addr == eik_pkg::ADDR_IF0,
                        mem_bit_sel, mem_wdata[0], mem_wdata);
    req2_nxt = eik_merge(req2_img, mem_wr && mem_addr == eik_pkg::ADDR_REQ2,
                         mem_bit_wr && mem_addr == eik_pkg::ADDR_REQ2,
                         mem_bit_sel, mem_wdata[0], mem_wdata);
    mk0_nxt = eik_merge(mk0_img, mem_wr && mem_addr == eik_pkg::ADDR_MK0,
                        mem_bit_wr && mem_addr == eik_pkg::ADDR_MK0,
                        mem_bit_sel, mem_wdata[0], mem_wdata);
    mask2_nxt = eik_merge(mask2_img, mem_wr && mem_addr == eik_pkg::ADDR_MASK2,
                          mem_bit_wr && mem_addr == eik_pkg::ADDR_MASK2,
                          mem_bit_sel, mem_wdata[0], mem_wdata);
  end

  // Request flags: event set wins over ack and software clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ext_req_r <= 4'h0;
      kr0_req_r <= 1'b0;
      kr6_req_r <= 1'b0;
    end else begin
      ext_req_r <= (if0_nxt[eik_pkg::IF0_EXT_LSB +: 4] & ~src_ack[3:0])
                   | ext_hit;
      kr0_req_r <= (req2_nxt[eik_pkg::REQ2_KR0_BIT]
                    & ~src_ack[eik_pkg::SRC_KR0]) | kr0_hit;
      kr6_req_r <= (req2_nxt[eik_pkg::REQ2_KR6_BIT]
                    & ~src_ack[eik_pkg::SRC_KR6]) | kr6_hit;
    end
  end

  // Mask flags
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ext_mask_r <= 4'hF;
      kr0_mask_r <= 1'b1;
      kr6_mask_r <= 1'b1;
    end else begin
      ext_mask_r <= mk0_nxt[eik_pkg::IF0_EXT_LSB +: 4];
      kr0_mask_r <= mask2_nxt[eik_pkg::REQ2_KR0_BIT];
      kr6_mask_r <= mask2_nxt[eik_pkg::REQ2_KR6_BIT];
    end
  end

  assign int_pending = {kr6_req_r & ~kr6_mask_r, kr0_req_r & ~kr0_mask_r,
                        ext_req_r & ~ext_mask_r};

  // Edge select registers: byte writes only, stored as written
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      edge_lo_r <= eik_pkg::RST_ZERO;
      edge_hi_r <= eik_pkg::RST_ZERO;
    end else begin
      if (mem_wr && mem_addr == eik_pkg::ADDR_EDGE_LO) begin
        edge_lo_r <= mem_wdata;
      end
      if (mem_wr && mem_addr == eik_pkg::ADDR_EDGE_HI) begin
        edge_hi_r <= mem_wdata;
      end
    end
  end

  // Key-return control registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      kr0_r <= eik_pkg::RST_ZERO;
      kr6_r <= eik_pkg::RST_ZERO;
    end else begin
      kr0_r <= eik_merge(kr0_r, mem_wr && mem_addr == eik_pkg::ADDR_KR0,
                         mem_bit_wr && mem_addr == eik_pkg::ADDR_KR0,
                         mem_bit_sel, mem_wdata[0], mem_wdata);
      kr6_r <= eik_merge(kr6_r, mem_wr && mem_addr == eik_pkg::ADDR_KR6,
                         mem_bit_wr && mem_addr == eik_pkg::ADDR_KR6,
                         mem_bit_sel, mem_wdata[0], mem_wdata);
    end
  end

  // Status word: acknowledge clear beats any same-cycle enable
  always_comb begin
    psw_nxt = psw_r;
    if (alu_flags_wr) begin
      psw_nxt = {psw_r[eik_pkg::PSW_IE_BIT], alu_flags[6:0]};
    end
    psw_nxt = eik_merge(psw_nxt, mem_wr && mem_addr == eik_pkg::ADDR_PSW,
                        mem_bit_wr && mem_addr == eik_pkg::ADDR_PSW,
                        mem_bit_sel, mem_wdata[0], mem_wdata);
    if (enable_int_instr) begin
      psw_nxt[eik_pkg::PSW_IE_BIT] = 1'b1;
    end
    if (disable_int_instr) begin
      psw_nxt[eik_pkg::PSW_IE_BIT] = 1'b0;
    end
    if (int_ack || nmi_start) begin
      psw_nxt[eik_pkg::PSW_IE_BIT] = 1'b0;
    end
    psw_nxt = (psw_nxt | eik_pkg::PSW_ONES) & ~eik_pkg::PSW_ZEROS;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      psw_r <= eik_pkg::RST_PSW;
    end else begin
      psw_r <= psw_nxt;
    end
  end

  assign processor_status_word = psw_r;

  // Non-maskable sequence; IE is not consulted at all
  assign nmi_start = (nmi_st_r == eik_pkg::ST_IDLE
                      || nmi_st_r == eik_pkg::ST_VEC)
                     && (nmi_req || nmi_pend_r);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      nmi_st_r   <= eik_pkg::ST_IDLE;
      nmi_pend_r <= 1'b0;
      pc_snap_r  <= 16'h0000;
      psw_snap_r <= eik_pkg::RST_ZERO;
    end else begin
      if (nmi_start) begin
        nmi_pend_r <= 1'b0;
      end else if (nmi_req) begin
        nmi_pend_r <= 1'b1;
      end
      if (nmi_start) begin
        nmi_st_r   <= eik_pkg::ST_PSW;
        pc_snap_r  <= cpu_pc;
        psw_snap_r <= psw_r;
      end else begin
        case (nmi_st_r)
          eik_pkg::ST_PSW: nmi_st_r <= eik_pkg::ST_PCH;
          eik_pkg::ST_PCH: nmi_st_r <= eik_pkg::ST_PCL;
          eik_pkg::ST_PCL: nmi_st_r <= eik_pkg::ST_VEC;
          default:         nmi_st_r <= eik_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Sequence outputs from flops: status first, then PC high and low
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      nmi_ack      <= 1'b0;
      push_wr      <= 1'b0;
      push_data    <= eik_pkg::RST_ZERO;
      pc_load      <= 1'b0;
      pc_load_addr <= 16'h0000;
    end else begin
      nmi_ack      <= nmi_start;
      push_wr      <= nmi_st_r == eik_pkg::ST_PSW
                      || nmi_st_r == eik_pkg::ST_PCH
                      || nmi_st_r == eik_pkg::ST_PCL;
      pc_load      <= nmi_st_r == eik_pkg::ST_VEC && !nmi_start;
      pc_load_addr <= NMI_VEC_ADDR;
      case (nmi_st_r)
        eik_pkg::ST_PSW: push_data <= psw_snap_r;
        eik_pkg::ST_PCH: push_data <= pc_snap_r[15:8];
        eik_pkg::ST_PCL: push_data <= pc_snap_r[7:0];
        default:         push_data <= push_data;
      endcase
    end
  end

  // Read decode
  always_comb begin
    rdata_nxt = eik_pkg::RST_ZERO;
    hit_nxt   = 1'b1;
    if (mem_addr == eik_pkg::ADDR_IF0) begin
      rdata_nxt = if0_img;
    end else if (mem_addr == eik_pkg::ADDR_REQ2) begin
      rdata_nxt = req2_img;
    end else if (mem_addr == eik_pkg::ADDR_MK0) begin
      rdata_nxt = mk0_img;
    end else if (mem_addr == eik_pkg::ADDR_MASK2) begin
      rdata_nxt = mask2_img;
    end else if (mem_addr == eik_pkg::ADDR_EDGE_LO) begin
      rdata_nxt = edge_lo_r;
    end else if (mem_addr == eik_pkg::ADDR_EDGE_HI) begin
      rdata_nxt = edge_hi_r;
    end else if (mem_addr == eik_pkg::ADDR_KR0) begin
      rdata_nxt = kr0_r;
    end else if (mem_addr == eik_pkg::ADDR_KR6) begin
      rdata_nxt = kr6_r;
    end else if (mem_addr == eik_pkg::ADDR_PSW) begin
      rdata_nxt = psw_r;
    end else begin
      hit_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mem_rdata <= eik_pkg::RST_ZERO;
      mem_hit   <= 1'b0;
    end else begin
      mem_rdata <= mem_rd ? rdata_nxt : eik_pkg::RST_ZERO;
      mem_hit   <= mem_rd && hit_nxt;
    end
  end

endmodule : eik_ctrl
`default_nettype wire

// File: hw/eik_pkg.sv
// Package of addresses, field positions and reset values for the block
package eik_pkg;
  localparam int           ADDR_W       = 16;
  localparam logic [15:0]  ADDR_IF0     = 16'hFFE0;
  localparam logic [15:0]  ADDR_REQ2    = 16'hFFE2;
  localparam logic [15:0]  ADDR_MK0     = 16'hFFE4;
  localparam logic [15:0]  ADDR_MASK2   = 16'hFFE6;
  localparam logic [15:0]  ADDR_EDGE_LO = 16'hFFEC;
  localparam logic [15:0]  ADDR_EDGE_HI = 16'hFFED;
  localparam logic [15:0]  ADDR_KR6     = 16'hFFF4;
  localparam logic [15:0]  ADDR_KR0     = 16'hFFF5;
  localparam logic [15:0]  ADDR_PSW     = 16'hFF1E;
  localparam logic [7:0]   RST_ZERO     = 8'h00;
  localparam logic [7:0]   RST_MASK     = 8'hFF;
  localparam logic [7:0]   RST_PSW      = 8'h02;
  localparam logic [7:0]   PSW_ONES     = 8'h02;
  localparam logic [7:0]   PSW_ZEROS    = 8'h2C;
  localparam int           PSW_IE_BIT   = 7;
  localparam int           EDGE_LO_LSB  = 2;
  localparam int           EDGE_HI_LSB  = 0;
  localparam int           IF0_EXT_LSB  = 1;
  localparam int           REQ2_KR0_BIT = 0;
  localparam int           REQ2_KR6_BIT = 5;
  localparam int           KR_GROUP_BIT = 0;
  localparam int           KR_LINE_LSB  = 4;
  localparam int           N_EXT        = 4;
  localparam int           N_SRC        = 6;
  localparam int           SRC_KR0      = 4;
  localparam int           SRC_KR6      = 5;
  localparam logic [1:0]   EDGE_FALL    = 2'h0;
  localparam logic [1:0]   EDGE_RISE    = 2'h1;
  localparam logic [1:0]   EDGE_BOTH    = 2'h3;
  localparam logic [15:0]  NMI_VECTOR   = 16'h0002;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PSW,
    ST_PCH,
    ST_PCL,
    ST_VEC
  } eik_nmi_state_t;
endpackage : eik_pkg

// File: verif/eik_ctrl_props.sv
// Port checker for the interrupt front end
`timescale 1ns/10ps
`default_nettype none
module eik_ctrl_props #(
  parameter logic [15:0] NMI_VEC_ADDR = eik_pkg::NMI_VECTOR
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rstn,
  // Register port
  input wire logic [15:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic [7:0]  mem_rdata,
  input wire logic        mem_hit,
  // Status word
  input wire logic        enable_int_instr,
  input wire logic        disable_int_instr,
  input wire logic [7:0]  processor_status_word,
  input wire logic        int_ack,
  // Non-maskable sequence
  input wire logic        nmi_req,
  input wire logic        nmi_ack,
  input wire logic        push_wr,
  input wire logic        pc_load,
  input wire logic [15:0] pc_load_addr
);
  logic [2:0] busy_r;
  logic       mapped;

  assign mapped = mem_addr inside {eik_pkg::ADDR_IF0, eik_pkg::ADDR_REQ2,
    eik_pkg::ADDR_MK0, eik_pkg::ADDR_MASK2, eik_pkg::ADDR_EDGE_LO,
    eik_pkg::ADDR_EDGE_HI, eik_pkg::ADDR_KR6, eik_pkg::ADDR_KR0,
    eik_pkg::ADDR_PSW};

  // Covers the sequence so a new request is judged only when idle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) busy_r <= 3'h0;
    else if (nmi_ack) busy_r <= 3'h4;
    else if (busy_r != 3'h0) busy_r <= busy_r - 3'h1;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_RD_MAP: assert property (mem_rd && !mapped |=>
    !mem_hit && mem_rdata == 8'h00) else $error("unmapped read answered");
  AST_RD_HIT: assert property (mem_rd && mapped |=> mem_hit)
    else $error("mapped read not answered");
  AST_PSW_FIX: assert property (
    (processor_status_word & 8'h2E) == 8'h02) else $error("fixed bits");
  AST_EI: assert property (enable_int_instr && !disable_int_instr
    && !int_ack && !nmi_req |=> processor_status_word[7])
    else $error("enable lost");
  AST_DI: assert property (disable_int_instr |=>
    !processor_status_word[7]) else $error("disable lost");
  AST_ACK_IE: assert property (int_ack |=>
    !processor_status_word[7]) else $error("ack kept enable");
  AST_NMI_TAKE: assert property (nmi_req && busy_r == 3'h0 &&
    !nmi_ack |=> nmi_ack) else $error("nmi not taken");
  AST_NMI_IE: assert property (nmi_ack |->
    !processor_status_word[7]) else $error("nmi kept enable");
  AST_NMI_SEQ: assert property (nmi_ack |=> push_wr ##1 push_wr
    ##1 push_wr ##1 (pc_load != nmi_ack && pc_load_addr == NMI_VEC_ADDR))
    else $error("nmi sequence wrong");
  AST_NMI_NEST: assert property (nmi_req && busy_r >= 3'h2 |->
    ##[1:4] nmi_ack) else $error("nested nmi not taken");

  COV_NMI: cover property (nmi_ack ##4 pc_load);
  COV_ACK: cover property (int_ack);
  COV_HIT: cover property (mem_rd ##1 mem_hit);
endmodule : eik_ctrl_props

bind eik_ctrl eik_ctrl_props #(.NMI_VEC_ADDR(NMI_VEC_ADDR)) u_props (
  .mclk(mclk), .rstn(rstn), .mem_addr(mem_addr), .mem_rd(mem_rd),
  .mem_rdata(mem_rdata), .mem_hit(mem_hit),
  .enable_int_instr(enable_int_instr),
  .disable_int_instr(disable_int_instr),
  .processor_status_word(processor_status_word), .int_ack(int_ack),
  .nmi_req(nmi_req), .nmi_ack(nmi_ack), .push_wr(push_wr),
  .pc_load(pc_load), .pc_load_addr(pc_load_addr));
`default_nettype wire

// File: verif/eik_ctrl_tb_top.sv
// Self-checking bench for the interrupt front end
`timescale 1ns/10ps
`default_nettype none
module eik_ctrl_tb_top;
  localparam logic [10:0] S_EI  = 11'h001;
  localparam logic [10:0] S_DI  = 11'h002;
  localparam logic [10:0] S_ACK = 11'h004;
  localparam logic [10:0] S_NMI = 11'h008;
  localparam logic [10:0] S_ALU = 11'h010;
  localparam logic [10:0] S_SRC = 11'h020;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] mem_addr = 16'h0000;
  logic        mem_wr = 1'b0;
  logic        mem_bit_wr = 1'b0;
  logic [2:0]  mem_bit_sel = 3'h0;
  logic [7:0]  mem_wdata = 8'h00;
  logic        mem_rd = 1'b0;
  logic [10:0] stb = 11'h000;
  logic [7:0]  alu_flags = 8'h00;
  logic [15:0] cpu_pc = 16'h0000;
  logic [3:0]  ext_lvl = 4'hF;
  logic [7:0]  p0_lvl = 8'hFF;
  logic [7:0]  p6_lvl = 8'hFF;
  logic [7:0]  mem_rdata, push_data, processor_status_word;
  logic [5:0]  int_pending;
  logic [15:0] pc_load_addr;
  logic        mem_hit, nmi_ack, push_wr, pc_load;
  logic [3:0]  ext_int_pin;
  logic [7:0]  port0_pin, port6_pin;
  int          seed = 2402;
  int          err_count = 0;
  int          n_compared = 0;

  always #50 mclk = ~mclk;

  eik_pin_model u_pins (.mclk(mclk), .ext_lvl(ext_lvl), .p0_lvl(p0_lvl),
    .p6_lvl(p6_lvl), .ext_int_pin(ext_int_pin), .port0_pin(port0_pin),
    .port6_pin(port6_pin));

  eik_ctrl DUT (.mclk(mclk), .rstn(rstn), .mem_addr(mem_addr),
    .mem_wr(mem_wr), .mem_bit_wr(mem_bit_wr), .mem_bit_sel(mem_bit_sel),
    .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .mem_hit(mem_hit), .enable_int_instr(stb[0]),
    .disable_int_instr(stb[1]), .alu_flags(alu_flags),
    .alu_flags_wr(stb[4]), .processor_status_word(processor_status_word),
    .int_ack(stb[2]), .src_ack(stb[10:5]), .int_pending(int_pending),
    .ext_int_pin(ext_int_pin), .port0_pin(port0_pin),
    .port6_pin(port6_pin), .nmi_req(stb[3]), .cpu_pc(cpu_pc),
    .nmi_ack(nmi_ack), .push_wr(push_wr), .push_data(push_data),
    .pc_load(pc_load), .pc_load_addr(pc_load_addr));

  function automatic logic fire(input logic [1:0] m, input logic rise);
    if (rise) return m == eik_pkg::EDGE_RISE || m == eik_pkg::EDGE_BOTH;
    return m == eik_pkg::EDGE_FALL || m == eik_pkg::EDGE_BOTH;
  endfunction : fire

  function automatic logic [7:0] psw_exp(input logic [7:0] v);
    return (v & ~eik_pkg::PSW_ZEROS) | eik_pkg::PSW_ONES;
  endfunction : psw_exp

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic b, input logic [2:0] s);
    @(negedge mclk);
    mem_addr = a;
    mem_wdata = d;
    mem_bit_sel = s;
    mem_wr = ~b;
    mem_bit_wr = b;
    @(negedge mclk);
    mem_wr = 1'b0;
    mem_bit_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge mclk);
    mem_addr = a;
    mem_rd = 1'b1;
    @(negedge mclk);
    mem_rd = 1'b0;
    chk(mem_rdata, e);
  endtask : rd

  task automatic pulse(input logic [10:0] m);
    @(negedge mclk);
    stb = m;
    @(negedge mclk);
    stb = 11'h000;
  endtask : pulse

  // Group 0 port 0, 1 port 6, 2 external pins; then let sync settle
  task automatic lines(input int g, input logic [7:0] v);
    @(negedge mclk);
    if (g == 0) p0_lvl = v;
    else if (g == 1) p6_lvl = v;
    else ext_lvl = v[3:0];
    repeat (8) @(negedge mclk);
  endtask : lines

  task automatic nmi_run;
    logic [7:0] ps;
    int         i;
    ps = processor_status_word;
    cpu_pc = 16'($random(seed));
    pulse(S_NMI);
    for (i = 0; i < 4 && nmi_ack !== 1'b1; i++) @(negedge mclk);
    if (i == 4) begin
      err_count++;
      conclude();
    end
    chk(processor_status_word[7], 1'b0);
    @(negedge mclk);
    chk({push_wr, push_data}, {1'b1, ps});
    @(negedge mclk);
    chk({push_wr, push_data}, {1'b1, cpu_pc[15:8]});
    @(negedge mclk);
    chk({push_wr, push_data}, {1'b1, cpu_pc[7:0]});
    @(negedge mclk);
    chk({pc_load, pc_load_addr}, {1'b1, eik_pkg::NMI_VECTOR});
  endtask : nmi_run

  initial begin
    logic [7:0]  v, lo, hi, mb;
    logic [15:0] ka;
    logic [1:0]  md;
    logic [2:0]  r;
    repeat (20) @(negedge mclk);
    rstn = 1'b1;
    chk(processor_status_word, eik_pkg::RST_PSW);
    chk(int_pending, 6'h00);
    rd(eik_pkg::ADDR_EDGE_LO, 8'h00);
    rd(eik_pkg::ADDR_EDGE_HI, 8'h00);
    rd(eik_pkg::ADDR_KR0, 8'h00);
    rd(eik_pkg::ADDR_KR6, 8'h00);
    rd(eik_pkg::ADDR_MASK2, eik_pkg::RST_MASK);
    chk(mem_hit, 1'b1);
    rd(16'hFFEE, 8'h00);
    chk(mem_hit, 1'b0);
    v = 8'($random(seed)) & 8'hFC;
    wr(eik_pkg::ADDR_EDGE_LO, v, 1'b0, 3'h0);
    wr(eik_pkg::ADDR_EDGE_LO, {7'h00, ~v[7]}, 1'b1, 3'h7);
    rd(eik_pkg::ADDR_EDGE_LO, v);
    for (int n = 0; n < 4; n++) begin
      for (int m = 0; m < 4; m++) begin
        md = 2'(m);
        lo = (n < 3) ? 8'(md) << (2 * n + 2) : 8'h00;
        hi = (n == 3) ? {6'h00, md} : 8'h00;
        wr(eik_pkg::ADDR_MK0, 8'hFF, 1'b0, 3'h0);
        wr(eik_pkg::ADDR_EDGE_LO, lo, 1'b0, 3'h0);
        wr(eik_pkg::ADDR_EDGE_HI, hi, 1'b0, 3'h0);
        wr(eik_pkg::ADDR_IF0, 8'h00, 1'b0, 3'h0);
        wr(eik_pkg::ADDR_MK0, 8'hFF ^ (8'h02 << n), 1'b0, 3'h0);
        lines(2, 8'hFF ^ (8'h01 << n));
        chk(int_pending[n], fire(md, 1'b0));
        pulse(S_SRC << n);
        chk(int_pending[n], 1'b0);
        lines(2, 8'hFF);
        chk(int_pending[n], fire(md, 1'b1));
        wr(eik_pkg::ADDR_IF0, 8'h00, 1'b0, 3'h0);
        rd(eik_pkg::ADDR_IF0, 8'h00);
      end
    end
    for (int k = 0; k < 2; k++) begin
      ka = k ? eik_pkg::ADDR_KR6 : eik_pkg::ADDR_KR0;
      mb = k ? 8'h20 : 8'h01;
      wr(eik_pkg::ADDR_MASK2, 8'hFF, 1'b0, 3'h0);
      wr(ka, 8'h01, 1'b1, 3'h0);
      wr(ka, 8'h01, 1'b1, 3'h6);
      rd(ka, 8'h41);
      wr(eik_pkg::ADDR_REQ2, 8'h00, 1'b0, 3'h0);
      wr(eik_pkg::ADDR_MASK2, 8'hFF ^ mb, 1'b0, 3'h0);
      lines(k, 8'hDF);
      chk(int_pending[4 + k], 1'b0);
      lines(k, 8'hFF);
      r = 3'($random(seed)) & 3'h3;
      lines(k, 8'hFF ^ (8'h01 << r));
      chk(int_pending[4 + k], 1'b1);
      wr(eik_pkg::ADDR_REQ2, 8'h00, 1'b0, 3'h0);
      // Group line still low hides the fall on line 6
      lines(k, 8'hBF ^ (8'h01 << r));
      chk(int_pending[4 + k], 1'b0);
      lines(k, 8'hFF);
      lines(k, 8'hBF);
      chk(int_pending[4 + k], 1'b1);
      pulse(S_SRC << (4 + k));
      chk(int_pending[4 + k], 1'b0);
      lines(k, 8'hFF);
    end
    pulse(S_EI);
    chk(processor_status_word, 8'h82);
    alu_flags = 8'($random(seed));
    pulse(S_ALU);
    chk(processor_status_word, psw_exp({1'b1, alu_flags[6:0]}));
    pulse(S_ACK);
    chk(processor_status_word[7], 1'b0);
    wr(eik_pkg::ADDR_PSW, 8'hFF, 1'b0, 3'h0);
    rd(eik_pkg::ADDR_PSW, psw_exp(8'hFF));
    wr(eik_pkg::ADDR_PSW, 8'h00, 1'b1, 3'h7);
    chk(processor_status_word[7], 1'b0);
    pulse(S_EI | S_DI);
    chk(processor_status_word[7], 1'b0);
    pulse(S_EI);
    nmi_run();
    repeat (2) @(negedge mclk);
    nmi_run();
    // Second request lands while the first is still pushing
    pulse(S_NMI);
    pulse(S_NMI);
    repeat (2) @(negedge mclk);
    chk({nmi_ack, pc_load}, 2'b10);
    repeat (4) @(negedge mclk);
    chk({pc_load, pc_load_addr}, {1'b1, eik_pkg::NMI_VECTOR});
    conclude();
  end
endmodule : eik_ctrl_tb_top
`default_nettype wire

// File: verif/eik_pin_model.sv
// Pin-side model driving interrupt and key lines
`timescale 1ns/10ps
`default_nettype none
module eik_pin_model (
  // Clock
  input  wire logic       mclk,
  // Requested levels
  input  wire logic [3:0] ext_lvl,
  input  wire logic [7:0] p0_lvl,
  input  wire logic [7:0] p6_lvl,
  // Pins
  output var  logic [3:0] ext_int_pin = 4'hF,
  output var  logic [7:0] port0_pin = 8'hFF,
  output var  logic [7:0] port6_pin = 8'hFF
);
  // Driven hard both ways, so no pull-up is assumed
  always @(posedge mclk) begin
    ext_int_pin <= ext_lvl;
    port0_pin   <= p0_lvl;
    port6_pin   <= p6_lvl;
  end
endmodule : eik_pin_model
`default_nettype wire
